// file: design/acs_delay_timer.sv
// Purpose: one-shot down counter for calibration, wake, sleep and switch delays
// Assumes: start reloads at any time, even while running
// Notes: expired pulses loadValue+1 cycles after start
`timescale 1ns/100ps
`default_nettype none
module acs_delay_timer
(
  input wire logic mclk,
  input wire logic sysRst,
  input wire logic start,
  input wire logic [acs_pkg::TIMER_W-1:0] loadValue,
  output logic expired
);
  import acs_pkg::*;

  logic [TIMER_W-1:0] cnt_reg;
  logic busy_reg;

  always_ff @(posedge mclk)
  begin
    if (sysRst)
    begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end
    else if (start)
    begin
      cnt_reg <= loadValue;
      busy_reg <= 1'b1;
    end
    else if (busy_reg)
    begin
      if (cnt_reg == '0)
        busy_reg <= 1'b0;
      else
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // no start term: the sequencer starts its next delay off this pulse, a loop otherwise
  assign expired = busy_reg && (cnt_reg == '0);

endmodule
`default_nettype wire

// file: design/acs_pkg.sv
// Purpose: shared constants and types for the converter core calibration sequencer
// Assumes: 32-bit AHB-Lite register access, one clock (converter sample clock)
// Notes: register byte address is four times the register index
package acs_pkg;

  localparam int DATA_W = 9;
  localparam int CORE_W = 3;
  localparam int NUM_CORES = 6;
  localparam int NUM_CH = 4;
  localparam int NUM_GRP = 2;
  localparam int DLY_W = 8;
  localparam int TIMER_W = 16;
  localparam int IDX_W = 10;
  localparam int ADDR_LSB = 2;
  localparam int DLY_SHIFT = 4;
  localparam int NUM_TRIM = 6;
  localparam int TRIM_SEL_W = 3;

  localparam logic [DATA_W-1:0] MUTE_CODE = 9'h000;
  localparam logic [TIMER_W-1:0] FG_CAL_CYCLES = 16'h0800;
  localparam logic [TIMER_W-1:0] BG_CAL_CYCLES = 16'h0200;

  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h090;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h091;
  localparam logic [IDX_W-1:0] IDX_SLEEP = 10'h092;
  localparam logic [IDX_W-1:0] IDX_WAKE = 10'h093;
  localparam logic [IDX_W-1:0] IDX_MAP = 10'h094;
  localparam logic [IDX_W-1:0] IDX_SRCSW = 10'h09A;
  localparam logic [IDX_W-1:0] IDX_OUTSEL = 10'h09B;
  localparam logic [IDX_W-1:0] IDX_TRIM = 10'h0A0;

  localparam logic [DLY_W-1:0] SWITCH_DLY_RST = 8'h00;
  localparam logic [DLY_W-1:0] SLEEP_DLY_RST = 8'h10;
  localparam logic [DLY_W-1:0] WAKE_DLY_RST = 8'h04;
  // arbitrary neutral stand-in for per-device factory trim
  localparam logic [NUM_TRIM*DLY_W-1:0] FACTORY_TRIM_DEFAULT = 48'h808080808080;

  localparam logic [CORE_W-1:0] CH_CORE_INIT [NUM_CH] = '{3'h0, 3'h1, 3'h4, 3'h5};
  localparam logic [CORE_W-1:0] SPARE_INIT [NUM_GRP] = '{3'h2, 3'h3};

  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FG = 3'h1,
    ST_WAKE = 3'h3,
    ST_CAL = 3'h2,
    ST_HOLD = 3'h6,
    ST_SWAP = 3'h7,
    ST_SLEEP = 3'h5
  } acs_state_e;

  typedef struct packed {
    logic statusSel;
    logic lowPowerManualSelect;
    logic lowPowerBgEnable;
    logic backgroundCalEnable;
    logic triggerSourceSelect;
    logic softwareCalTrigger;
  } acs_ctrl_s;

  localparam int CTRL_W = $bits(acs_ctrl_s);
  localparam acs_ctrl_s CTRL_RST = '0;

  typedef struct packed {
    acs_state_e state;
    logic groupSel;
    logic spareCalFinished;
    logic calActive;
    logic fgBusy;
    logic foregroundDoneFlag;
  } acs_status_s;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
  } acs_ahb_req_s;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } acs_ahb_rsp_s;

  typedef logic [NUM_CH-1:0][DATA_W-1:0] acs_chan_data_t;
  typedef logic [NUM_CORES-1:0][DATA_W-1:0] acs_core_data_t;

endpackage

// file: design/acs_sequencer.sv
// Purpose: foreground / background / low-power background calibration sequencer
// Assumes: cal trigger pin is asynchronous; AHB-Lite master single word transfers
// Notes: reads take one wait state, writes none
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer
#(
  parameter int CHANNELS = 4,
  parameter logic [acs_pkg::NUM_TRIM*acs_pkg::DLY_W-1:0] FACTORY_TRIM = acs_pkg::FACTORY_TRIM_DEFAULT
)
(
  input wire logic mclk,
  input wire logic sysRst,
  input wire acs_pkg::acs_ahb_req_s ahbReq,
  input wire logic hready,
  output acs_pkg::acs_ahb_rsp_s ahbRsp,
  input wire logic calTriggerPin,
  input wire acs_pkg::acs_core_data_t coreSample,
  output acs_pkg::acs_chan_data_t dataOut,
  output logic dataMute,
  output logic [acs_pkg::NUM_CORES-1:0] corePowerOn,
  output logic [acs_pkg::CORE_W-1:0] calCoreIndex,
  output logic calActive,
  output logic calStatusPin
);
  import acs_pkg::*;

  localparam int GROUPS = (CHANNELS == 4) ? 2 : 1;
  localparam logic PAIRED = (CHANNELS > 1);

  acs_state_e state_reg, state_next;
  acs_ctrl_s ctrlReg;
  logic [DLY_W-1:0] sleepDly_reg, wakeDly_reg, srcSwDly_reg, outSelDly_reg;
  logic [DLY_W-1:0] trimRead [NUM_TRIM];
  logic [TRIM_SEL_W-1:0] trimSel;
  logic [CORE_W-1:0] chanCore_reg [NUM_CH];
  logic [CORE_W-1:0] spareCore_reg [NUM_GRP];
  logic [NUM_GRP-1:0] ptr_reg;
  logic groupSel_reg;
  logic trigMeta_reg, trigSync_reg, trigPrev_reg;
  logic fgPending_reg, fgDone_reg;
  logic wrPend_reg, rdWait_reg, addrOk_reg;
  logic [IDX_W-1:0] regIdx_reg;
  logic [31:0] hrdata_reg, rdValue, wdata;
  logic accept, writeHit, trigLevel, trigRise, bgRun, lpOn, manual;
  logic tStart, tDone, swapNow, fgStart, fgEnd, fgBusy, spareAwake, spareCalFinished;
  logic [TIMER_W-1:0] tLoad;
  logic [1:0] swapChan;
  logic [CORE_W-1:0] swapInCore;
  logic [NUM_CORES-1:0] coreIsLive;
  logic calStatus_reg, dataMute_reg;
  acs_chan_data_t dataOut_reg;
  acs_status_s statusWord;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sysRst);

  function automatic logic [TIMER_W-1:0] dlyCycles(input logic [DLY_W-1:0] v);
    return TIMER_W'(v) << DLY_SHIFT;
  endfunction

  // bus slave
  assign accept = ahbReq.hsel && hready && ahbReq.htrans[1];
  assign writeHit = wrPend_reg && addrOk_reg;
  assign wdata = ahbReq.hwdata;

  always_ff @(posedge mclk)
  begin
    if (sysRst)
    begin
      wrPend_reg <= 1'b0;
      rdWait_reg <= 1'b0;
      addrOk_reg <= 1'b0;
      regIdx_reg <= '0;
    end
    else
    begin
      wrPend_reg <= accept && ahbReq.hwrite;
      rdWait_reg <= accept && !ahbReq.hwrite;
      if (accept)
      begin
        regIdx_reg <= ahbReq.haddr[IDX_W+ADDR_LSB-1:ADDR_LSB];
        addrOk_reg <= (ahbReq.haddr[31:IDX_W+ADDR_LSB] == '0) && (ahbReq.haddr[ADDR_LSB-1:0] == '0);
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sysRst)
      hrdata_reg <= '0;
    else if (rdWait_reg)
      hrdata_reg <= rdValue;
  end

  assign ahbRsp.hreadyout = !rdWait_reg;
  assign ahbRsp.hresp = HRESP_OKAY;
  assign ahbRsp.hrdata = hrdata_reg;

  always_ff @(posedge mclk)
  begin
    if (sysRst)
    begin
      ctrlReg <= CTRL_RST;
      sleepDly_reg <= SLEEP_DLY_RST;
      wakeDly_reg <= WAKE_DLY_RST;
      srcSwDly_reg <= SWITCH_DLY_RST;
      outSelDly_reg <= SWITCH_DLY_RST;
    end
    else if (writeHit)
    begin
      if (regIdx_reg == IDX_CTRL)
        ctrlReg <= acs_ctrl_s'(wdata[CTRL_W-1:0]);
      else if (regIdx_reg == IDX_SLEEP)
        sleepDly_reg <= wdata[DLY_W-1:0];
      else if (regIdx_reg == IDX_WAKE)
        wakeDly_reg <= wdata[DLY_W-1:0];
      else if (regIdx_reg == IDX_SRCSW)
        srcSwDly_reg <= wdata[DLY_W-1:0];
      else if (regIdx_reg == IDX_OUTSEL)
        outSelDly_reg <= wdata[DLY_W-1:0];
    end
  end

  // trims come out of reset at the factory value and stay writable
  for (genvar t = 0; t < NUM_TRIM; t++)
  begin : g_trim
    logic [DLY_W-1:0] val_reg;
    always_ff @(posedge mclk)
    begin
      if (sysRst)
        val_reg <= FACTORY_TRIM[t*DLY_W +: DLY_W];
      else if (writeHit && regIdx_reg == IDX_TRIM + IDX_W'(t))
        val_reg <= wdata[DLY_W-1:0];
    end
    assign trimRead[t] = val_reg;
  end

  assign trimSel = TRIM_SEL_W'(regIdx_reg - IDX_TRIM);
  assign statusWord = '{state_reg, groupSel_reg, spareCalFinished, calActive, fgBusy, fgDone_reg};

  always_comb
  begin
    rdValue = '0;
    if (!addrOk_reg)
      rdValue = '0;
    else if (regIdx_reg == IDX_CTRL)
      rdValue = 32'(ctrlReg);
    else if (regIdx_reg == IDX_STATUS)
      rdValue = 32'(statusWord);
    else if (regIdx_reg == IDX_SLEEP)
      rdValue = 32'(sleepDly_reg);
    else if (regIdx_reg == IDX_WAKE)
      rdValue = 32'(wakeDly_reg);
    else if (regIdx_reg == IDX_MAP)
      rdValue = 32'({spareCore_reg[1], spareCore_reg[0], chanCore_reg[3], chanCore_reg[2],
                     chanCore_reg[1], chanCore_reg[0]});
    else if (regIdx_reg == IDX_SRCSW)
      rdValue = 32'(srcSwDly_reg);
    else if (regIdx_reg == IDX_OUTSEL)
      rdValue = 32'(outSelDly_reg);
    else if (regIdx_reg >= IDX_TRIM && regIdx_reg < IDX_TRIM + IDX_W'(NUM_TRIM))
      rdValue = 32'(trimRead[trimSel]);
  end

  // trigger source and edge
  always_ff @(posedge mclk)
  begin
    if (sysRst)
    begin
      trigMeta_reg <= 1'b0;
      trigSync_reg <= 1'b0;
    end
    else
    begin
      trigMeta_reg <= calTriggerPin;
      trigSync_reg <= trigMeta_reg;
    end
  end

  assign trigLevel = ctrlReg.triggerSourceSelect ? trigSync_reg : ctrlReg.softwareCalTrigger;
  assign trigRise = trigLevel && !trigPrev_reg;
  assign lpOn = ctrlReg.lowPowerBgEnable;
  assign manual = lpOn && ctrlReg.lowPowerManualSelect;
  // manual low-power runs on its own; otherwise the trigger must stay high
  assign bgRun = ctrlReg.backgroundCalEnable && (manual || trigLevel);

  always_ff @(posedge mclk)
  begin
    if (sysRst)
      trigPrev_reg <= 1'b0;
    else
      trigPrev_reg <= trigLevel;
  end

  // power-up calibration pending from reset; new request wins over clear
  always_ff @(posedge mclk)
  begin
    if (sysRst)
      fgPending_reg <= 1'b1;
    else if (trigRise && !ctrlReg.backgroundCalEnable)
      fgPending_reg <= 1'b1;
    else if (fgStart)
      fgPending_reg <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (sysRst)
      fgDone_reg <= 1'b0;
    else if (fgEnd)
      fgDone_reg <= 1'b1;
    else if (fgStart)
      fgDone_reg <= 1'b0;
  end

  acs_delay_timer u_timer
  (
    .mclk(mclk),
    .sysRst(sysRst),
    .start(tStart),
    .loadValue(tLoad),
    .expired(tDone)
  );

  always_comb
  begin
    state_next = state_reg;
    tStart = 1'b0;
    tLoad = '0;
    swapNow = 1'b0;
    fgStart = 1'b0;
    fgEnd = 1'b0;
    case (state_reg)
      ST_IDLE:
        if (fgPending_reg)
        begin
          state_next = ST_FG;
          fgStart = 1'b1;
          tStart = 1'b1;
          tLoad = FG_CAL_CYCLES;
        end
        else if (bgRun && lpOn)
        begin
          state_next = ST_SLEEP;
          tStart = !manual;
          tLoad = dlyCycles(sleepDly_reg);
        end
        else if (bgRun)
        begin
          state_next = ST_CAL;
          tStart = 1'b1;
          tLoad = BG_CAL_CYCLES;
        end
      ST_FG:
        if (tDone)
        begin
          state_next = ST_IDLE;
          fgEnd = 1'b1;
        end
      ST_SLEEP:
        if (!bgRun)
          state_next = ST_IDLE;
        else if ((manual && !trigLevel) || (!manual && tDone))
        begin
          state_next = ST_WAKE;
          tStart = 1'b1;
          tLoad = dlyCycles(wakeDly_reg);
        end
      ST_WAKE:
        if (!bgRun)
          state_next = ST_IDLE;
        else if (tDone)
        begin
          state_next = ST_CAL;
          tStart = 1'b1;
          tLoad = BG_CAL_CYCLES;
        end
      ST_CAL:
        if (!bgRun)
          state_next = ST_IDLE;
        else if (tDone && manual)
          state_next = ST_HOLD;
        else if (tDone)
        begin
          state_next = ST_SWAP;
          tStart = 1'b1;
          tLoad = dlyCycles(srcSwDly_reg);
        end
      ST_HOLD:
        if (!bgRun)
          state_next = ST_IDLE;
        else if (trigLevel)
        begin
          state_next = ST_SWAP;
          tStart = 1'b1;
          tLoad = dlyCycles(srcSwDly_reg);
        end
      ST_SWAP:
        if (tDone)
        begin
          swapNow = 1'b1;
          if (lpOn)
          begin
            state_next = ST_SLEEP;
            tStart = !manual;
            tLoad = dlyCycles(sleepDly_reg);
          end
          else
          begin
            state_next = ST_CAL;
            tStart = 1'b1;
            tLoad = BG_CAL_CYCLES;
          end
        end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sysRst)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // core rotation; a swap only exchanges the calibrated spare with one channel
  assign swapChan = {groupSel_reg, ptr_reg[groupSel_reg]};
  assign swapInCore = spareCore_reg[groupSel_reg];

  always_ff @(posedge mclk)
  begin
    if (sysRst)
    begin
      chanCore_reg <= CH_CORE_INIT;
      spareCore_reg <= SPARE_INIT;
      ptr_reg <= '0;
      groupSel_reg <= 1'b0;
    end
    else if (swapNow)
    begin
      chanCore_reg[swapChan] <= swapInCore;
      spareCore_reg[groupSel_reg] <= chanCore_reg[swapChan];
      ptr_reg[groupSel_reg] <= PAIRED ? !ptr_reg[groupSel_reg] : 1'b0;
      groupSel_reg <= (GROUPS == 2) ? !groupSel_reg : 1'b0;
    end
  end

  assign fgBusy = (state_reg == ST_FG);
  assign calActive = (state_reg == ST_CAL);
  assign calCoreIndex = swapInCore;
  assign spareAwake = (state_reg == ST_WAKE) || calActive || (state_reg == ST_HOLD) || (state_reg == ST_SWAP);
  assign spareCalFinished = (state_reg == ST_HOLD) || (state_reg == ST_SWAP);

  always_comb
  begin
    coreIsLive = '0;
    for (int c = 0; c < CHANNELS; c++)
      coreIsLive[chanCore_reg[c]] = 1'b1;
    corePowerOn = coreIsLive | {NUM_CORES{fgBusy}};
    for (int g = 0; g < GROUPS; g++)
      // a spare still busy stays powered while background is being switched off
      if ((groupSel_reg == g[0] && spareAwake) || (ctrlReg.backgroundCalEnable && !lpOn))
        corePowerOn[spareCore_reg[g]] = 1'b1;
  end

  // unused channels of smaller variants stay at MUTE_CODE (zero)
  always_ff @(posedge mclk)
  begin
    if (sysRst)
    begin
      dataOut_reg <= '0;
      dataMute_reg <= 1'b0;
      calStatus_reg <= 1'b0;
    end
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
        dataOut_reg[c] <= (fgBusy || c >= CHANNELS) ? MUTE_CODE : coreSample[chanCore_reg[c]];
      dataMute_reg <= fgBusy;
      calStatus_reg <= ctrlReg.statusSel ? spareCalFinished : fgBusy;
    end
  end

  assign dataOut = dataOut_reg;
  assign dataMute = dataMute_reg;
  assign calStatusPin = calStatus_reg;

  a_fg_mute_out: assert property (fgBusy |=> dataMute && dataOut == '0)
    else $error("output not muted during foreground calibration");
  a_fg_powerup: assert property ($fell(sysRst) |-> ##1 state_reg == ST_FG)
    else $error("no foreground calibration after reset");
  a_spare_groups: assert property (spareCore_reg[0] inside {3'h0, 3'h1, 3'h2}
                                   && spareCore_reg[1] inside {3'h3, 3'h4, 3'h5})
    else $error("spare left its core group");
  a_one_cal_core: assert property (calActive |-> corePowerOn[calCoreIndex] && !coreIsLive[calCoreIndex])
    else $error("calibrated core is also live");
  a_swap_exchange: assert property (swapNow |=> chanCore_reg[$past(swapChan)] == $past(swapInCore)
                                    && spareCore_reg[$past(groupSel_reg)] == $past(chanCore_reg[swapChan]))
    else $error("swap did not exchange spare and channel core");
  a_lp_spare_dark: assert property (lpOn && state_reg == ST_SLEEP |-> !corePowerOn[swapInCore])
    else $error("sleeping spare is powered");
  a_auto_swap: assert property (calActive && tDone && bgRun && !manual |=> state_reg == ST_SWAP)
    else $error("automatic mode did not swap after calibration");
  a_manual_sleep: assert property (state_reg == ST_SLEEP && manual && trigLevel && bgRun |=> state_reg == ST_SLEEP)
    else $error("spare woke while trigger high");
  a_manual_wake: assert property (state_reg == ST_SLEEP && manual && !trigLevel && bgRun |=> state_reg == ST_WAKE)
    else $error("trigger low did not wake spare");
  a_manual_hold: assert property (state_reg == ST_HOLD && bgRun |=> state_reg == ($past(trigLevel) ? ST_SWAP : ST_HOLD))
    else $error("manual swap not gated by trigger");
  a_status_select: assert property (ctrlReg.statusSel && spareCalFinished |=> calStatusPin)
    else $error("status pin missed spare finished");
  a_foreground_done_flag_flag: assert property (fgBusy && tDone |=> fgDone_reg && state_reg == ST_IDLE)
    else $error("foreground done flag not set");

  c_foreground_done_flag: cover property (fgBusy && tDone);
  c_swap: cover property (swapNow && lpOn);
  c_hold_wait: cover property (state_reg == ST_HOLD ##1 state_reg == ST_HOLD ##1 state_reg == ST_SWAP);

endmodule
`default_nettype wire

// file: dv/acs_host_model.sv
// Purpose: far-side stand-in: calibration trigger pin and per-core sample values
// Assumes: fire is a one-cycle request from the bench, sampled at the rising edge
// Notes: each core carries its own constant so routing shows at dataOut
`timescale 1ns/100ps
`default_nettype none
module acs_host_model
(
  input wire logic mclk,
  input wire logic fire,
  output logic calTriggerPin,
  output acs_pkg::acs_core_data_t coreSample
);
  import acs_pkg::*;
  logic [2:0] holdCnt = 3'h0;
  // pin held high four cycles so the double synchroniser cannot miss it
  always_ff @(posedge mclk)
  begin
    if (fire)
      holdCnt <= 3'h4;
    else if (holdCnt != 3'h0)
      holdCnt <= holdCnt - 3'h1;
  end
  assign calTriggerPin = (holdCnt != 3'h0);
  always_comb
  begin
    for (int k = 0; k < NUM_CORES; k++)
      coreSample[k] = 9'h100 + DATA_W'(k);
  end
endmodule
`default_nettype wire

// file: dv/adc_core_calibration_sequencer_bench.sv
// Purpose: self-checking bench for the calibration sequencer over AHB-Lite
// Assumes: one slave, so hready is the slave's own hreadyout
// Notes: a second reset in mid-run restarts power-up calibration
`timescale 1ns/100ps
`default_nettype none
module adc_core_calibration_sequencer_bench;
  import acs_pkg::*;
  logic mclk;
  logic sysRst;
  logic fire;
  acs_ahb_req_s ahbReq;
  acs_ahb_rsp_s ahbRsp;
  logic calTriggerPin;
  acs_core_data_t coreSample;
  acs_chan_data_t dataOut;
  logic dataMute;
  logic [NUM_CORES-1:0] corePowerOn;
  logic [CORE_W-1:0] calCoreIndex;
  logic calActive;
  logic calStatusPin;
  logic [31:0] rd;
  int errors;
  int samples_checked;
  int cycles;
  int n;

  acs_sequencer #(.CHANNELS(4)) dut (.mclk(mclk), .sysRst(sysRst), .ahbReq(ahbReq), .hready(ahbRsp.hreadyout),
    .ahbRsp(ahbRsp), .calTriggerPin(calTriggerPin), .coreSample(coreSample), .dataOut(dataOut),
    .dataMute(dataMute), .corePowerOn(corePowerOn), .calCoreIndex(calCoreIndex), .calActive(calActive),
    .calStatusPin(calStatusPin));
  acs_host_model host (.mclk(mclk), .fire(fire), .calTriggerPin(calTriggerPin), .coreSample(coreSample));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic finish_test();
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // whole run needs roughly 7000 cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; no fixed wait, hready decides
  task automatic ahb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd, output logic [31:0] rdat);
    ahbReq.hsel <= 1'b1;
    ahbReq.htrans <= 2'h2;
    ahbReq.haddr <= {20'h00000, idx, 2'h0};
    ahbReq.hwrite <= wr;
    ahbReq.hsize <= 3'h2;
    @(posedge mclk);
    while (ahbRsp.hreadyout !== 1'b1) @(posedge mclk);
    ahbReq.hsel <= 1'b0;
    ahbReq.htrans <= 2'h0;
    ahbReq.hwdata <= wd;
    @(posedge mclk);
    while (ahbRsp.hreadyout !== 1'b1) @(posedge mclk);
    rdat = ahbRsp.hrdata;
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] wd);
    logic [31:0] dummy;
    ahb(1'b1, idx, wd, dummy);
  endtask

  task automatic rdchk(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    logic [31:0] got;
    ahb(1'b0, idx, 32'h0, got);
    chk(got, exp);
  endtask

  task automatic restart();
    sysRst <= 1'b1;
    repeat (3) @(posedge mclk);
    sysRst <= 1'b0;
    repeat (5) @(posedge mclk);
    chk({31'h0, dataMute}, 32'h1);
    for (int c = 0; c < NUM_CH; c++)
      chk({23'h0, dataOut[c]}, {23'h0, MUTE_CODE});
    rd = 32'h0;
    // host waits for the done flag before any configuration
    while (rd[0] !== 1'b1) ahb(1'b0, IDX_STATUS, 32'h0, rd);
    chk({23'h0, dataOut[0]}, 32'h100);
    chk({23'h0, dataOut[2]}, 32'h104);
  endtask

  initial
  begin
    ahbReq = '0;
    sysRst = 1'b1;
    fire = 1'b0;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    @(posedge mclk);
    restart();
    rdchk(IDX_SLEEP, 32'h10);
    rdchk(IDX_WAKE, 32'h04);
    rdchk(IDX_SRCSW, 32'h00);
    rdchk(IDX_OUTSEL, 32'h00);
    rdchk(IDX_MAP, 32'h1AB08);
    for (n = 0; n < NUM_TRIM; n++)
      rdchk(IDX_TRIM + IDX_W'(n), {24'h0, FACTORY_TRIM_DEFAULT[8*n +: 8]});
    wr(IDX_TRIM + 10'h002, 32'h5A);
    rdchk(IDX_TRIM + 10'h002, 32'h5A);
    wr(IDX_SRCSW, 32'h1F);
    wr(IDX_OUTSEL, 32'h1E);
    rdchk(IDX_SRCSW, 32'h1F);
    rdchk(IDX_OUTSEL, 32'h1E);
    rdchk(10'h3FF, 32'h0);
    chk({31'h0, ahbRsp.hresp}, {31'h0, HRESP_OKAY});
    // low-power manual: software bit is the trigger, status pin shows spare finished
    wr(IDX_CTRL, 32'h3D);
    repeat (20) @(posedge mclk);
    rdchk(IDX_STATUS, 32'hA1);
    chk({31'h0, corePowerOn[2]}, 32'h0);
    wr(IDX_CTRL, 32'h3C);
    n = 0;
    while (calActive !== 1'b1)
    begin
      @(posedge mclk);
      n++;
    end
    chk(32'(n >= 64 && n <= 68), 32'h1);
    chk({29'h0, calCoreIndex}, 32'h2);
    chk({31'h0, corePowerOn[2]}, 32'h1);
    while (calStatusPin !== 1'b1) @(posedge mclk);
    repeat (100) @(posedge mclk);
    chk({30'h0, calStatusPin, calActive}, 32'h2);
    rdchk(IDX_MAP, 32'h1AB08);
    wr(IDX_CTRL, 32'h3D);
    n = 0;
    while (calStatusPin !== 1'b0)
    begin
      @(posedge mclk);
      n++;
    end
    chk(32'(n >= 494 && n <= 503), 32'h1);
    repeat (4) @(posedge mclk);
    rdchk(IDX_MAP, 32'h18B0A);
    // mid-run reset, then plain background rotation
    restart();
    wr(IDX_CTRL, 32'h05);
    while (calActive !== 1'b1) @(posedge mclk);
    chk({29'h0, calCoreIndex}, 32'h2);
    while (calActive !== 1'b0) @(posedge mclk);
    while (calActive !== 1'b1) @(posedge mclk);
    chk({29'h0, calCoreIndex}, 32'h3);
    // output register follows the new map one cycle after the swap
    @(posedge mclk);
    chk({23'h0, dataOut[0]}, 32'h102);
    chk({31'h0, dataMute}, 32'h0);
    // low-power automatic: swap, timed sleep, timed wake, then core 0 calibrates
    wr(IDX_CTRL, 32'h0D);
    while (calActive !== 1'b0) @(posedge mclk);
    n = 0;
    while (calActive !== 1'b1)
    begin
      @(posedge mclk);
      n++;
      if (n == 10)
        chk({31'h0, corePowerOn[0]}, 32'h0);
    end
    chk(32'(n >= 321 && n <= 325), 32'h1);
    chk({29'h0, calCoreIndex}, 32'h0);
    // foreground from the pin once background is off
    wr(IDX_CTRL, 32'h02);
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    n = 0;
    while (dataMute !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    chk({31'h0, dataMute}, 32'h1);
    @(posedge mclk);
    chk({23'h0, dataOut[1]}, {23'h0, MUTE_CODE});
    ahb(1'b0, IDX_STATUS, 32'h0, rd);
    chk({31'h0, rd[1]}, 32'h1);
    finish_test();
  end
endmodule
`default_nettype wire
